// >>> hbic_top.sv
// What this block does
// - four address inputs select the register each bus cycle targets
// - register decode and transfers happen only while chip select is low
// - io request, read and select low: addressed register drives data bus
// - io request and select low, read high: data bus written to register
// - io request with machine cycle one is an acknowledge returning a vector
// - machine cycle one with read low: opcode fetch watched for return
// - snooped return instruction clears the active unit's in-service flag
// - chain enable in high required before requesting or acknowledging
// - chain enable out low while this or higher device requests or serves
// - reset puts both parallel ports in mode 1, handshakes off, and irqs off until the clock after reset ends
// - reset makes port c all inputs and active
// - reset stops timers, disables their irqs and both serial channels until the clock after reset ends
// - divided clock output is half the crystal frequency
// - terminal-ready a and b drive inverse bit on port c bits 5 and 2
// - send-request a and b drive inverse bit on port c bits 4 and 3
// - sync pins a and b share port c bits 6 and 1
// - wait/ready a and b on port c bits 7 and 0, drive low only
// - command bit 7 set hands shared port c pins to serial signals
// - chain order from bits 2..0, loaded only when bit 3 is set
`timescale 1ns/1ns
`default_nettype none
module hbic_top
	import hbic_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       crystal_in,
	// cpu bus
	input  wire logic [3:0] addr_i,
	input  wire logic       chip_sel_n_i,
	input  wire logic       io_request_n_i,
	input  wire logic       read_n_i,
	input  wire logic       machine_cycle_one_n_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] data_o,
	output logic            data_oe_o,
	// daisy chain
	input  wire logic       int_enable_in_i,
	output logic            int_enable_out_o,
	// unit requests and vectors from the sub-units
	input  wire logic [2:0] unit_req_i,
	input  wire logic [7:0] vec_pio_i,
	input  wire logic [7:0] vec_ctc_i,
	input  wire logic [7:0] vec_sio_i,
	input  wire logic [7:0] unit_rdata_i,
	// register strobes to sub-units
	output logic            unit_wr_o,
	output logic            unit_rd_o,
	output logic      [3:0] unit_addr_o,
	output logic      [7:0] unit_wdata_o,
	// reset state of sub-units
	output logic      [1:0] pio_mode_o,
	output logic            pio_irq_en_o,
	output logic            ctc_run_o,
	output logic            sio_en_o,
	output logic      [2:0] in_service_o,
	output logic      [2:0] chain_order_o,
	// serial control signals
	input  wire logic       dtr_a_i,
	input  wire logic       dtr_b_i,
	input  wire logic       rts_a_i,
	input  wire logic       rts_b_i,
	input  wire logic       sync_a_i,
	input  wire logic       sync_b_i,
	input  wire logic       wrdy_a_i,
	input  wire logic       wrdy_b_i,
	output logic            sync_pin_a_n_o,
	output logic            sync_pin_b_n_o,
	// port c pins
	input  wire logic [7:0] port_c_i,
	output logic      [7:0] port_c_o,
	output logic      [7:0] port_c_oe_o,
	output logic            divided_clock_out
);
	// ********************************************************
	// bus decode
	// ********************************************************
	logic       sel;
	logic       rd_cyc;
	logic       wr_cyc;
	logic       ack_cyc;
	logic       fetch_cyc;
	logic       wr_seen_reg;
	logic [7:0] cmd_reg;
	logic [7:0] pc_data_reg;
	logic [7:0] pc_dir_reg;
	logic [2:0] order_reg;
	hbic_ret_t  ret_reg;
	logic       ret_pulse;
	logic [2:0] grant;
	logic [2:0] svc;
	logic [3:0] ie_chain;
	logic [1:0] slot_unit [3];
	logic [2:0] req_slot;
	logic [2:0] svc_slot;
	logic [7:0] ack_vec;
	logic       ack_have;

	// select gates register reads and writes; acknowledge is never a register cycle
	assign sel       = ~chip_sel_n_i & ~io_request_n_i & machine_cycle_one_n_i;
	assign rd_cyc    = sel & ~read_n_i;
	assign wr_cyc    = sel & read_n_i;
	assign ack_cyc   = ~io_request_n_i & ~machine_cycle_one_n_i;
	assign fetch_cyc = ~machine_cycle_one_n_i & ~read_n_i & io_request_n_i;

	// the write lasts several clocks on the bus; act on its first one only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_seen_reg <= 1'b0;
		end else begin
			wr_seen_reg <= wr_cyc;
		end
	end

	// ********************************************************
	// local registers: port c and command
	// ********************************************************
	// reset clears the command, so port c is general purpose and input
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_reg     <= HBIC_RST_BYTE;
			pc_data_reg <= HBIC_RST_BYTE;
			pc_dir_reg  <= HBIC_RST_PC_DIR;
		end else if (wr_cyc && !wr_seen_reg) begin
			case (addr_i)
				HBIC_REG_PC_DATA: pc_data_reg <= data_i;
				HBIC_REG_PC_DIR:  pc_dir_reg  <= data_i;
				HBIC_REG_CMD:     cmd_reg     <= data_i;
				default: ;
			endcase
		end
	end

	// order only moves when the load bit accompanies it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			order_reg <= HBIC_RST_ORDER;
		end else if (wr_cyc && !wr_seen_reg && addr_i == HBIC_REG_CMD
				&& data_i[HBIC_CMD_CHAIN_WR]) begin
			order_reg <= data_i[HBIC_CMD_ORDER_LSB +: 3];
		end
	end

	// sub-unit state forced at hardware reset; enables turn back on the clock after reset ends
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pio_mode_o   <= HBIC_RST_PIO_MODE;
			pio_irq_en_o <= 1'b0;
			ctc_run_o    <= 1'b0;
			sio_en_o     <= 1'b0;
		end else begin
			pio_mode_o   <= pio_mode_o;
			pio_irq_en_o <= 1'b1;
			ctc_run_o    <= 1'b1;
			sio_en_o     <= 1'b1;
		end
	end

	// register strobes to the sub-units; write pulses once per bus cycle, read strobe lasts the whole read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unit_wr_o    <= 1'b0;
			unit_rd_o    <= 1'b0;
			unit_addr_o  <= 4'h0;
			unit_wdata_o <= 8'h00;
		end else begin
			unit_wr_o    <= wr_cyc & ~wr_seen_reg & (addr_i < HBIC_REG_PC_DATA);
			unit_rd_o    <= rd_cyc & (addr_i < HBIC_REG_PC_DATA);
			unit_addr_o  <= addr_i;
			unit_wdata_o <= data_i;
		end
	end

	// ********************************************************
	// return snoop
	// ********************************************************
	// prefix followed by the return opcode in consecutive fetches
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ret_reg <= HBIC_RS_IDLE;
		end else if (fetch_cyc) begin
			case (ret_reg)
				HBIC_RS_IDLE:   ret_reg <= (data_i == HBIC_OP_PREFIX) ? HBIC_RS_PREFIX : HBIC_RS_IDLE;
				HBIC_RS_PREFIX: ret_reg <= (data_i == HBIC_OP_PREFIX) ? HBIC_RS_PREFIX : HBIC_RS_IDLE;
				default:        ret_reg <= HBIC_RS_IDLE;
			endcase
		end
	end
	assign ret_pulse = fetch_cyc && ret_reg == HBIC_RS_PREFIX && data_i == HBIC_OP_RET;

	// ********************************************************
	// daisy chain
	// ********************************************************
	// order code picks which unit sits in each slot; codes over 5 give no units
	function automatic logic [1:0] hbic_slot(input logic [2:0] ord, input int s);
		logic [1:0] u;
		u = HBIC_U_NONE;
		case (ord)
			3'h0: u = (s == 0) ? HBIC_U_SIO : (s == 1) ? HBIC_U_CTC : HBIC_U_PIO;
			3'h1: u = (s == 0) ? HBIC_U_SIO : (s == 1) ? HBIC_U_PIO : HBIC_U_CTC;
			3'h2: u = (s == 0) ? HBIC_U_CTC : (s == 1) ? HBIC_U_SIO : HBIC_U_PIO;
			3'h3: u = (s == 0) ? HBIC_U_PIO : (s == 1) ? HBIC_U_SIO : HBIC_U_CTC;
			3'h4: u = (s == 0) ? HBIC_U_CTC : (s == 1) ? HBIC_U_PIO : HBIC_U_SIO;
			3'h5: u = (s == 0) ? HBIC_U_PIO : (s == 1) ? HBIC_U_CTC : HBIC_U_SIO;
			default: u = HBIC_U_NONE;
		endcase
		return u;
	endfunction : hbic_slot

	assign ie_chain[0] = int_enable_in_i;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_slot
			assign slot_unit[g] = hbic_slot(order_reg, g);
			assign req_slot[g]  = (slot_unit[g] == HBIC_U_NONE) ? 1'b0
				: unit_req_i[slot_unit[g]];
			hbic_chain_unit u_unit (
				.clk_i             (clk_i),
				.rst_i             (rst_i),
				.ie_in_i           (ie_chain[g]),
				.req_i             (req_slot[g]),
				.ack_i             (ack_cyc),
				.ret_i             (ret_pulse),
				.in_service_flag_o (svc_slot[g]),
				.ie_out_o          (ie_chain[g+1]),
				.grant_o           (grant[g])
			);
		end
	endgenerate

	// map slot flags back to unit positions for the status outputs
	always_comb begin
		svc = 3'h0;
		for (int s = 0; s < 3; s++) begin
			if (slot_unit[s] != HBIC_U_NONE) begin
				svc[slot_unit[s]] = svc_slot[s];
			end
		end
	end

	// vector of the highest granted slot
	always_comb begin
		ack_vec  = 8'h00;
		ack_have = 1'b0;
		for (int s = 2; s >= 0; s--) begin
			if (grant[s]) begin
				ack_have = 1'b1;
				case (slot_unit[s])
					HBIC_U_PIO: ack_vec = vec_pio_i;
					HBIC_U_CTC: ack_vec = vec_ctc_i;
					HBIC_U_SIO: ack_vec = vec_sio_i;
					default:    ack_vec = 8'h00;
				endcase
			end
		end
	end

	// chain outputs registered; one clock of lag on enable out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_enable_out_o <= 1'b0;
			in_service_o     <= 3'h0;
			chain_order_o    <= HBIC_RST_ORDER;
		end else begin
			int_enable_out_o <= ie_chain[3];
			in_service_o     <= svc;
			chain_order_o    <= order_reg;
		end
	end

	// ********************************************************
	// data bus
	// ********************************************************
	// read data appears on the clock edge after the cycle is seen
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_o    <= 8'h00;
			data_oe_o <= 1'b0;
		end else if (ack_cyc && ack_have && int_enable_in_i) begin
			data_o    <= ack_vec;
			data_oe_o <= 1'b1;
		end else if (ack_cyc && data_oe_o) begin
			// the granted unit turns in-service at once and drops its grant,
			// so the vector is held here for the rest of the acknowledge
			data_oe_o <= 1'b1;
		end else if (rd_cyc) begin
			data_oe_o <= 1'b1;
			case (addr_i)
				HBIC_REG_PC_DATA: data_o <= (port_c_i & pc_dir_reg) | (pc_data_reg & ~pc_dir_reg);
				HBIC_REG_PC_DIR:  data_o <= pc_dir_reg;
				HBIC_REG_CMD:     data_o <= cmd_reg;
				HBIC_REG_CMD_B:   data_o <= cmd_reg;
				default:          data_o <= unit_rdata_i;
			endcase
		end else begin
			data_oe_o <= 1'b0;
		end
	end

	// ********************************************************
	// port c sharing
	// ********************************************************
	// wait/ready pins only pull low, so the enable follows the active level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_c_o       <= 8'h00;
			port_c_oe_o    <= 8'h00;
			sync_pin_a_n_o <= 1'b1;
			sync_pin_b_n_o <= 1'b1;
		end else if (cmd_reg[HBIC_CMD_SERSEL_BIT]) begin
			port_c_o                 <= 8'h00;
			port_c_o[HBIC_PC_DTR_A]  <= ~dtr_a_i;
			port_c_o[HBIC_PC_DTR_B]  <= ~dtr_b_i;
			port_c_o[HBIC_PC_RTS_A]  <= ~rts_a_i;
			port_c_o[HBIC_PC_RTS_B]  <= ~rts_b_i;
			port_c_oe_o              <= 8'h00;
			port_c_oe_o[HBIC_PC_DTR_A] <= 1'b1;
			port_c_oe_o[HBIC_PC_DTR_B] <= 1'b1;
			port_c_oe_o[HBIC_PC_RTS_A] <= 1'b1;
			port_c_oe_o[HBIC_PC_RTS_B] <= 1'b1;
			port_c_oe_o[HBIC_PC_WRDY_A] <= wrdy_a_i;
			port_c_oe_o[HBIC_PC_WRDY_B] <= wrdy_b_i;
			port_c_oe_o[HBIC_PC_SYNC_A] <= sync_a_i;
			port_c_oe_o[HBIC_PC_SYNC_B] <= sync_b_i;
			sync_pin_a_n_o <= port_c_i[HBIC_PC_SYNC_A];
			sync_pin_b_n_o <= port_c_i[HBIC_PC_SYNC_B];
		end else begin
			port_c_o       <= pc_data_reg;
			port_c_oe_o    <= ~pc_dir_reg;
			sync_pin_a_n_o <= 1'b1;
			sync_pin_b_n_o <= 1'b1;
		end
	end

	hbic_clkdiv u_div (
		.crystal_in        (crystal_in),
		.rst_i             (rst_i),
		.divided_clock_out (divided_clock_out)
	);

	// ********************************************************
	// checks
	// ********************************************************
	property p_read_drive;
		@(posedge clk_i) disable iff (rst_i)
		(rd_cyc && !ack_cyc) |=> data_oe_o;
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read not driven");
	property p_no_sel_quiet;
		@(posedge clk_i) disable iff (rst_i)
		(chip_sel_n_i && !ack_cyc) |=> !data_oe_o && !unit_wr_o;
	endproperty
	a_no_sel_quiet: assert property (p_no_sel_quiet) else $error("drive while deselected");
	property p_cmd_write;
		@(posedge clk_i) disable iff (rst_i)
		(wr_cyc && !wr_seen_reg && addr_i == HBIC_REG_CMD) |=> cmd_reg == $past(data_i);
	endproperty
	a_cmd_write: assert property (p_cmd_write) else $error("command not stored");
	property p_order_hold;
		@(posedge clk_i) disable iff (rst_i)
		(wr_cyc && addr_i == HBIC_REG_CMD && !data_i[HBIC_CMD_CHAIN_WR]) |=> $stable(order_reg);
	endproperty
	a_order_hold: assert property (p_order_hold) else $error("order changed without load bit");
	property p_ieo_block;
		@(posedge clk_i) disable iff (rst_i)
		(!int_enable_in_i || (|svc)) |=> !int_enable_out_o;
	endproperty
	a_ieo_block: assert property (p_ieo_block) else $error("chain not blocked");
	property p_no_grant;
		@(posedge clk_i) disable iff (rst_i)
		!int_enable_in_i |-> grant == 3'h0;
	endproperty
	a_no_grant: assert property (p_no_grant) else $error("grant without enable");
	sequence s_ret_seq;
		fetch_cyc && data_i == HBIC_OP_PREFIX ##1 fetch_cyc && data_i == HBIC_OP_RET;
	endsequence
	property p_ret_seen;
		@(posedge clk_i) disable iff (rst_i)
		s_ret_seq |-> ret_pulse;
	endproperty
	a_ret_seen: assert property (p_ret_seen) else $error("return not recognised");
	property p_rts_inv;
		@(posedge clk_i) disable iff (rst_i)
		cmd_reg[HBIC_CMD_SERSEL_BIT] |=> port_c_o[HBIC_PC_RTS_A] == !$past(rts_a_i);
	endproperty
	a_rts_inv: assert property (p_rts_inv) else $error("send request not inverted");
	property p_pc_gp;
		@(posedge clk_i) disable iff (rst_i)
		!cmd_reg[HBIC_CMD_SERSEL_BIT] |=> port_c_oe_o == ~$past(pc_dir_reg);
	endproperty
	a_pc_gp: assert property (p_pc_gp) else $error("port c direction wrong");
endmodule : hbic_top
`default_nettype wire

// >>> hbic_pkg.sv
package hbic_pkg;
	// register indices on the four address lines
	localparam logic [3:0] HBIC_REG_PIOA_DATA  = 4'h0;
	localparam logic [3:0] HBIC_REG_PIOA_CMD   = 4'h1;
	localparam logic [3:0] HBIC_REG_PIOB_DATA  = 4'h2;
	localparam logic [3:0] HBIC_REG_PIOB_CMD   = 4'h3;
	localparam logic [3:0] HBIC_REG_CTC0       = 4'h4;
	localparam logic [3:0] HBIC_REG_CTC3       = 4'h7;
	localparam logic [3:0] HBIC_REG_SIOA_DATA  = 4'h8;
	localparam logic [3:0] HBIC_REG_SIOB_CMD   = 4'hB;
	localparam logic [3:0] HBIC_REG_PC_DATA    = 4'hC;
	localparam logic [3:0] HBIC_REG_PC_DIR     = 4'hD;
	localparam logic [3:0] HBIC_REG_CMD        = 4'hE;
	localparam logic [3:0] HBIC_REG_CMD_B      = 4'hF;
	// command register fields
	localparam int HBIC_CMD_SERSEL_BIT = 7;
	localparam int HBIC_CMD_CHAIN_WR   = 3;
	localparam int HBIC_CMD_ORDER_LSB  = 0;
	// shared port c bit positions
	localparam int HBIC_PC_WRDY_B = 0;
	localparam int HBIC_PC_SYNC_B = 1;
	localparam int HBIC_PC_DTR_B  = 2;
	localparam int HBIC_PC_RTS_B  = 3;
	localparam int HBIC_PC_RTS_A  = 4;
	localparam int HBIC_PC_DTR_A  = 5;
	localparam int HBIC_PC_SYNC_A = 6;
	localparam int HBIC_PC_WRDY_A = 7;
	// reset values
	localparam logic [7:0] HBIC_RST_PC_DIR = 8'hFF; // all inputs
	localparam logic [7:0] HBIC_RST_BYTE   = 8'h00;
	localparam logic [2:0] HBIC_RST_ORDER  = 3'h0;
	localparam logic [1:0] HBIC_RST_PIO_MODE = 2'h1;
	// opcode bytes of the return sequence
	localparam logic [7:0] HBIC_OP_PREFIX = 8'hED;
	localparam logic [7:0] HBIC_OP_RET    = 8'h4D;
	// unit identifiers in the chain
	localparam logic [1:0] HBIC_U_PIO = 2'h0;
	localparam logic [1:0] HBIC_U_CTC = 2'h1;
	localparam logic [1:0] HBIC_U_SIO = 2'h2;
	localparam logic [1:0] HBIC_U_NONE = 2'h3;
	// minimum reset hold, in system clocks
	localparam int HBIC_RST_MIN_CYC = 3;
	typedef enum logic [1:0] {HBIC_RS_IDLE, HBIC_RS_PREFIX} hbic_ret_t;
endpackage : hbic_pkg

// >>> hbic_clkdiv.sv
`timescale 1ns/1ns
`default_nettype none
module hbic_clkdiv
	import hbic_pkg::*;
(
	// crystal clock domain of the divider
	input  wire logic crystal_in,
	input  wire logic rst_i,
	// divided output
	output logic      divided_clock_out
);
	// toggle on every rising crystal edge gives half the frequency
	always_ff @(posedge crystal_in) begin
		if (rst_i) begin
			divided_clock_out <= 1'b0;
		end else begin
			divided_clock_out <= ~divided_clock_out;
		end
	end
endmodule : hbic_clkdiv
`default_nettype wire

// >>> hbic_chain_unit.sv
`timescale 1ns/1ns
`default_nettype none
module hbic_chain_unit
	import hbic_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// chain and bus events
	input  wire logic       ie_in_i,
	input  wire logic       req_i,
	input  wire logic       ack_i,
	input  wire logic       ret_i,
	// state
	output logic            in_service_flag_o,
	output logic            ie_out_o,
	output logic            grant_o
);
	logic svc_reg;
	// a unit whose enable is low may neither request nor be acknowledged
	assign grant_o = ie_in_i & req_i & ~svc_reg;
	// in-service set on acknowledge; return clears only the active unit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			svc_reg <= 1'b0;
		end else if (ack_i && grant_o) begin
			svc_reg <= 1'b1;
		end else if (ret_i && ie_in_i) begin
			svc_reg <= 1'b0;
		end
	end
	assign in_service_flag_o = svc_reg;
	// block lower units while requesting or in service
	assign ie_out_o = ie_in_i & ~req_i & ~svc_reg;
endmodule : hbic_chain_unit
`default_nettype wire

// >>> hbic_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// cpu bus master model
// ****
module hbic_cpu_model
	import hbic_pkg::*;
(
	// clock and answer
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       oe_i,
	// bus strobes, data
	output logic      [3:0] addr_o,
	output logic      [3:0] ctl_o,
	output logic      [7:0] data_o
);
	// idle bus; ctl is cs_n, io_request_n_n, rd_n, m1_n
	initial begin
		addr_o = 4'h0;
		ctl_o = 4'hF;
		data_o = 8'h00;
	end

	// one cycle held for three edges, answer taken after the second
	task automatic cyc(input logic [3:0] a, input logic [3:0] ctl, input logic [7:0] d,
		output logic [7:0] q, output logic oe);
		@(posedge clk_i);
		addr_o <= a;
		ctl_o <= ctl;
		data_o <= d;
		repeat (2) @(posedge clk_i);
		#1;
		q = rdata_i;
		oe = oe_i;
		@(posedge clk_i);
		ctl_o <= 4'hF;
		data_o <= ~d; // released bus never shows the last byte
		#1;
	endtask : cyc

	// prefix then a second byte on consecutive fetch clocks
	task automatic fetch2(input logic [7:0] op2);
		@(posedge clk_i);
		ctl_o <= 4'hC;
		data_o <= HBIC_OP_PREFIX;
		@(posedge clk_i);
		data_o <= op2;
		@(posedge clk_i);
		ctl_o <= 4'hF;
		data_o <= ~op2;
		// one more edge so the registered in-service status has settled
		@(posedge clk_i);
		#1;
	endtask : fetch2
endmodule : hbic_cpu_model
`default_nettype wire

// >>> hbic_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module hbic_top_tb_top
	import hbic_pkg::*;
;
	// ****
	// bench signals
	// ****
	localparam logic [3:0] WR = 4'h3, WR_NS = 4'hB, RD = 4'h1, RD_NS = 4'h9, ACK = 4'hA;
	localparam logic [7:0] VP = 8'h10, VC = 8'h22, VS = 8'h34;
	logic       clk_i, rst_i, crystal_in, int_enable_in, int_enable_out, doe, uwr, urd, oe;
	logic       pirq, crun, sen, spa, spb, dclk;
	logic [3:0] addr, ctl, uaddr, wr_a;
	logic [7:0] din, dout, rdata, wdat, wr_d, q, ser, pc_ext, pc_in, pc_o, pc_oe;
	logic [2:0] req, in_svc, order;
	logic [1:0] pmode;
	int         n_fail = 0, num_checks = 0, wr_cnt = 0, rd_cnt = 0;

	// pins of port c resolve from both drivers
	assign pc_in = (pc_o & pc_oe) | (pc_ext & ~pc_oe);

	hbic_top hbic_top_inst (.clk_i(clk_i), .rst_i(rst_i), .crystal_in(crystal_in),
		.addr_i(addr), .chip_sel_n_i(ctl[3]), .io_request_n_i(ctl[2]), .read_n_i(ctl[1]),
		.machine_cycle_one_n_i(ctl[0]), .data_i(din), .data_o(dout), .data_oe_o(doe),
		.int_enable_in_i(int_enable_in), .int_enable_out_o(int_enable_out), .unit_req_i(req), .vec_pio_i(VP),
		.vec_ctc_i(VC), .vec_sio_i(VS), .unit_rdata_i(rdata), .unit_wr_o(uwr),
		.unit_rd_o(urd), .unit_addr_o(uaddr), .unit_wdata_o(wdat), .pio_mode_o(pmode),
		.pio_irq_en_o(pirq), .ctc_run_o(crun), .sio_en_o(sen), .in_service_o(in_svc),
		.chain_order_o(order), .dtr_a_i(ser[0]), .dtr_b_i(ser[1]), .rts_a_i(ser[2]),
		.rts_b_i(ser[3]), .sync_a_i(ser[4]), .sync_b_i(ser[5]), .wrdy_a_i(ser[6]),
		.wrdy_b_i(ser[7]), .sync_pin_a_n_o(spa), .sync_pin_b_n_o(spb),
		.port_c_i(pc_in), .port_c_o(pc_o), .port_c_oe_o(pc_oe), .divided_clock_out(dclk));

	hbic_cpu_model hbic_cpu_model_inst (.clk_i(clk_i), .rdata_i(dout), .oe_i(doe),
		.addr_o(addr), .ctl_o(ctl), .data_o(din));

	// system clock stands in for the cpu clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// crystal unrelated in phase to the system clock
	initial begin
		crystal_in = 1'b0;
		forever #13 crystal_in = ~crystal_in;
	end
	// strobe monitor: pulses are too short to see from inside the tasks
	always @(posedge clk_i) begin
		if (uwr === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			wr_a <= uaddr;
			wr_d <= wdat;
		end
		if (urd === 1'b1)
			rd_cnt <= rd_cnt + 1;
	end

	// ****
	// shared tasks
	// ****
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic bus(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d);
		hbic_cpu_model_inst.cyc(a, c, d, q, oe);
	endtask : bus

	task automatic ack_chk(input logic [7:0] v, input logic [2:0] svc, input logic e);
		bus(ACK, 4'h0, 8'h00);
		chk("ack oe", 8'(oe), 8'(e));
		if (e)
			chk("vector", q, v);
		chk("in service", 8'(in_svc), 8'(svc));
	endtask : ack_chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// ****
	// scenarios
	// ****
	task automatic t_regs();
		int c0;
		c0 = wr_cnt;
		bus(WR, 4'h5, 8'h3C);
		chk("wr count", 8'(wr_cnt - c0), 8'h01);
		chk("wr addr", 8'(wr_a), 8'h05);
		chk("wr data", wr_d, 8'h3C);
		bus(WR_NS, 4'h6, 8'hC3);
		chk("wr ignored", 8'(wr_cnt - c0), 8'h01);
		@(posedge clk_i);
		rdata <= 8'h5A;
		c0 = rd_cnt;
		bus(RD, 4'h9, 8'h00);
		chk("rd data", q, 8'h5A);
		chk("rd oe", 8'(oe), 8'h01);
		chk("rd strobe", 8'(rd_cnt > c0), 8'h01);
		repeat (2) @(posedge clk_i);
		#1;
		chk("bus released", 8'(doe), 8'h00);
		bus(RD_NS, 4'h9, 8'h00);
		chk("rd ignored", 8'(oe), 8'h00);
		$display("test regs done");
	endtask : t_regs

	task automatic t_order();
		for (int c = 0; c < 8; c++) begin
			bus(WR, HBIC_REG_CMD, {5'h01, c[2:0]});
			chk("order", 8'(order), 8'(c));
		end
		bus(WR, HBIC_REG_CMD, 8'h02);
		chk("order kept", 8'(order), 8'h07);
		bus(WR, HBIC_REG_CMD, 8'h08);
		$display("test order done");
	endtask : t_order

	task automatic t_portc();
		bus(WR, HBIC_REG_PC_DIR, 8'hF0);
		bus(WR, HBIC_REG_PC_DATA, 8'hA5);
		chk("pc oe", pc_oe, 8'h0F);
		chk("pc out", pc_o & 8'h0F, 8'h05);
		@(posedge clk_i);
		ser <= 8'h69;
		bus(WR, HBIC_REG_CMD, 8'h88);
		repeat (3) @(posedge clk_i);
		#1;
		chk("ser oe", pc_oe, 8'hBE);
		chk("ser out", pc_o & pc_oe, 8'h14);
		chk("sync a", 8'(spa), 8'h01);
		chk("sync b", 8'(spb), 8'h00);
		bus(WR, HBIC_REG_CMD, 8'h08);
		ser <= 8'h00;
		$display("test port c done");
	endtask : t_portc

	task automatic t_int();
		repeat (4) @(posedge clk_i);
		chk("ieo idle", 8'(int_enable_out), 8'h01);
		req <= 3'b011;
		repeat (4) @(posedge clk_i);
		chk("ieo req", 8'(int_enable_out), 8'h00);
		ack_chk(VC, 3'b010, 1'b1);
		req <= 3'b001;
		hbic_cpu_model_inst.fetch2(8'h00);
		chk("no return", 8'(in_svc), 8'h02);
		chk("ieo serve", 8'(int_enable_out), 8'h00);
		hbic_cpu_model_inst.fetch2(HBIC_OP_RET);
		chk("return", 8'(in_svc), 8'h00);
		ack_chk(VP, 3'b001, 1'b1);
		req <= 3'b000;
		hbic_cpu_model_inst.fetch2(HBIC_OP_RET);
		repeat (4) @(posedge clk_i);
		chk("ieo free", 8'(int_enable_out), 8'h01);
		bus(WR, HBIC_REG_CMD, 8'h0D);
		req <= 3'b110;
		ack_chk(VC, 3'b010, 1'b1);
		req <= 3'b000;
		hbic_cpu_model_inst.fetch2(HBIC_OP_RET);
		int_enable_in <= 1'b0;
		req <= 3'b100;
		repeat (4) @(posedge clk_i);
		chk("ieo blocked", 8'(int_enable_out), 8'h00);
		ack_chk(VS, 3'b000, 1'b0);
		int_enable_in <= 1'b1;
		req <= 3'b000;
		bus(WR, HBIC_REG_CMD, 8'h08);
		$display("test interrupt done");
	endtask : t_int

	task automatic t_clk();
		logic p;
		@(negedge crystal_in);
		p = dclk;
		repeat (6) begin
			@(negedge crystal_in);
			chk("div clk", 8'(dclk), 8'(!p));
			p = dclk;
		end
		$display("test clock done");
	endtask : t_clk

	// ****
	// main sequence and watchdog
	// ****
	initial begin
		rst_i = 1'b1;
		int_enable_in = 1'b1;
		req = 3'h0;
		rdata = 8'h00;
		ser = 8'h00;
		pc_ext = 8'hFF;
		repeat (3) @(posedge clk_i);
		#1;
		chk("pio mode", 8'(pmode), 8'(HBIC_RST_PIO_MODE));
		chk("pio irq", 8'(pirq), 8'h00);
		chk("ctc run", 8'(crun), 8'h00);
		chk("sio en", 8'(sen), 8'h00);
		chk("pc oe rst", pc_oe, 8'h00);
		chk("bus rst", 8'(doe), 8'h00);
		@(posedge clk_i);
		rst_i <= 1'b0; // held four cycles
		@(posedge clk_i);
		bus(WR, HBIC_REG_CMD, 8'h08); // reprogrammed after reset
		chk("pio irq run", 8'(pirq), 8'h01);
		chk("ctc run on", 8'(crun), 8'h01);
		chk("sio en on", 8'(sen), 8'h01);
		chk("pio mode run", 8'(pmode), 8'(HBIC_RST_PIO_MODE));
		t_regs();
		t_order();
		t_portc();
		t_int();
		t_clk();
		stop_test();
	end
	// the tests take about 150 cycles; allow well beyond that
	initial begin
		#200000;
		n_fail++;
		stop_test();
	end
endmodule : hbic_top_tb_top
`default_nettype wire
